// file: design/shift_bank_pkg.sv
// Package of operation codes, carriers and constants for the shift and register bank slice.
// Summary of operation
// - Left shifts move bits up one place; outgoing top bit goes to carry.
// - Right shifts move bits down; bottom bit to carry; zero when result is zero.
// - Zero-fill left shift inserts 0 at bottom; zero only if bits 6:0 zero.
// - Zero-fill right shift inserts 0 at top; zero only if bits 7:1 zero.
// - One-fill shifts insert 1 and always clear the zero flag.
// - Replicate left shift repeats old bottom bit; zero from whole result.
// - Replicate right shift repeats old top bit, sign extending; zero from result.
// - Carry-through left shift puts old carry at bottom, top bit to carry.
// - Carry-through right shift puts old carry at top, bottom bit to carry.
// - Rotate left feeds top bit to bottom and into carry.
// - Rotate right feeds bottom bit to top and into carry.
// - Rotates set zero only when the register held zero before.
// - Thirty-two registers as two banks, A and B, of sixteen each.
// - One bank active; all but alternate store touch only the active bank.
// - Reset makes bank A active.
// - Bank select makes the named bank active, the other inactive.
// - One shared carry and zero flag, unchanged by bank select.
// - Changing bank alters no stored register contents.
// - A bank switch completes in one instruction cycle of two clocks.
// - Alternate store writes inactive-bank register from active register or constant.
// - Alternate store leaves carry and zero unchanged.
// - Same index as source and destination still copies across banks.
package shift_bank_pkg;

    localparam int unsigned DATA_WIDTH = 8;
    localparam int unsigned REG_COUNT = 16;
    localparam int unsigned INDEX_WIDTH = 4;
    localparam int unsigned CYCLE_CLOCKS = 2;
    localparam logic BANK_A = 1'b0;
    localparam logic BANK_B = 1'b1;
    localparam logic RESET_BANK = BANK_A;
    localparam logic [DATA_WIDTH-1:0] REG_RESET_VALUE = 8'h00;

    typedef enum logic [3:0] {
        op_none,
        shift_left_fill_zero,
        shift_left_fill_one,
        shift_left_replicate,
        shift_left_through_carry,
        shift_right_fill_zero,
        shift_right_fill_one,
        shift_right_replicate,
        shift_right_through_carry,
        rotate_left,
        rotate_right,
        bank_select,
        alternate_store,
        read_register
    } op_type;

    typedef struct packed {
        op_type op;
        logic [INDEX_WIDTH-1:0] target_register;
        logic [INDEX_WIDTH-1:0] source_register;
        logic [DATA_WIDTH-1:0] immediate_constant;
        logic use_constant;
        logic bank_b;
    } command_type;

    typedef struct packed {
        logic [DATA_WIDTH-1:0] data;
        logic carry;
        logic zero;
        logic bank_b;
    } result_type;

endpackage : shift_bank_pkg

// file: design/shift_bank_core.sv
// Shift, rotate and dual register bank datapath slice.
`timescale 1ns/100ps

module shift_bank_core (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Command from instruction decode
    input wire logic cmd_valid_i,
    input wire shift_bank_pkg::command_type cmd_i,
    // Results and state
    output shift_bank_pkg::result_type result_o,
    output logic result_valid_o,
    output logic busy_o
);
    import shift_bank_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    typedef enum logic [0:0] {
        idle_st,
        exec_st
    } state_type;

    state_type state_reg;
    command_type cmd_reg;
    // Index 0..15 is bank A, 16..31 is bank B.
    logic [DATA_WIDTH-1:0] regs_reg [2*REG_COUNT];
    logic bank_reg;
    logic carry_reg;
    logic zero_reg;
    logic [DATA_WIDTH-1:0] target_value;
    logic [DATA_WIDTH-1:0] source_value;
    logic [DATA_WIDTH-1:0] shift_data;
    logic shift_carry;
    logic shift_zero;
    logic is_shift;

    function automatic logic [INDEX_WIDTH:0] phys_index(input logic bank,
                                                        input logic [INDEX_WIDTH-1:0] idx);
        phys_index = {bank, idx};
    endfunction : phys_index

    ////////////////////////////////////////////////////////////////////////////////

    // two-clock cycle
    // Commands are taken only in idle, so every instruction spans two clocks.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= idle_st;
        end else begin
            unique case (state_reg)
                idle_st: begin
                    if (cmd_valid_i) begin
                        state_reg <= exec_st;
                    end
                end
                exec_st: begin
                    state_reg <= idle_st;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_reg <= '0;
        end else if (state_reg == idle_st && cmd_valid_i) begin
            cmd_reg <= cmd_i;
        end
    end

    assign target_value = regs_reg[phys_index(bank_reg, cmd_reg.target_register)];
    assign source_value = regs_reg[phys_index(bank_reg, cmd_reg.source_register)];

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        shift_data = target_value;
        shift_carry = carry_reg;
        is_shift = 1'b1;
        unique case (cmd_reg.op)
            shift_left_fill_zero: begin
                shift_data = {target_value[6:0], 1'b0};
                shift_carry = target_value[7];
            end
            shift_left_fill_one: begin
                shift_data = {target_value[6:0], 1'b1};
                shift_carry = target_value[7];
            end
            shift_left_replicate: begin
                shift_data = {target_value[6:0], target_value[0]};
                shift_carry = target_value[7];
            end
            shift_left_through_carry: begin
                shift_data = {target_value[6:0], carry_reg};
                shift_carry = target_value[7];
            end
            shift_right_fill_zero: begin
                shift_data = {1'b0, target_value[7:1]};
                shift_carry = target_value[0];
            end
            shift_right_fill_one: begin
                shift_data = {1'b1, target_value[7:1]};
                shift_carry = target_value[0];
            end
            shift_right_replicate: begin
                shift_data = {target_value[7], target_value[7:1]};
                shift_carry = target_value[0];
            end
            shift_right_through_carry: begin
                shift_data = {carry_reg, target_value[7:1]};
                shift_carry = target_value[0];
            end
            rotate_left: begin
                shift_data = {target_value[6:0], target_value[7]};
                shift_carry = target_value[7];
            end
            rotate_right: begin
                shift_data = {target_value[0], target_value[7:1]};
                shift_carry = target_value[0];
            end
            default: begin
                is_shift = 1'b0;
            end
        endcase
    end

    // zero from result
    // A rotated value is zero exactly when its input was, so one test serves all.
    assign shift_zero = (shift_data == REG_RESET_VALUE);

    ////////////////////////////////////////////////////////////////////////////////

    // register banks
    // Bank select writes no register; only shifts and alternate store do.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 2 * REG_COUNT; i++) begin
                regs_reg[i] <= REG_RESET_VALUE;
            end
        end else if (state_reg == exec_st) begin
            if (is_shift) begin
                regs_reg[phys_index(bank_reg, cmd_reg.target_register)] <= shift_data;
            end else if (cmd_reg.op == alternate_store) begin
                regs_reg[phys_index(~bank_reg, cmd_reg.target_register)] <=
                    cmd_reg.use_constant ? cmd_reg.immediate_constant : source_value;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bank_reg <= RESET_BANK;
        end else if (state_reg == exec_st && cmd_reg.op == bank_select) begin
            bank_reg <= cmd_reg.bank_b ? BANK_B : BANK_A;
        end
    end

    // shared flags
    // Flags change only for shifts and rotates, never for bank select or store.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            carry_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else if (state_reg == exec_st && is_shift) begin
            carry_reg <= shift_carry;
            zero_reg <= shift_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Outputs are registered copies so they stand beside the state they report.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_o <= '0;
            result_valid_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_reg == idle_st) && cmd_valid_i;
            result_valid_o <= (state_reg == exec_st);
            if (state_reg == exec_st) begin
                result_o.data <= is_shift ? shift_data :
                    (cmd_reg.op == read_register ? target_value : result_o.data);
                result_o.carry <= is_shift ? shift_carry : carry_reg;
                result_o.zero <= is_shift ? shift_zero : zero_reg;
                result_o.bank_b <= (cmd_reg.op == bank_select) ? cmd_reg.bank_b : bank_reg;
            end
        end
    end

endmodule : shift_bank_core

// file: verif/shift_bank_properties.sv
// Port assertions for the shift and register bank slice.
`timescale 1ns/100ps
module shift_bank_properties (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Command and result
    input wire logic cmd_valid_i,
    input wire shift_bank_pkg::command_type cmd_i,
    input wire shift_bank_pkg::result_type result_o,
    input wire logic result_valid_o,
    input wire logic busy_o
);
    import shift_bank_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    logic take;
    // A command is only taken when the core is not executing one.
    assign take = cmd_valid_i && !busy_o;
    property p_busy; take |=> busy_o; endproperty
    a_busy: assert property (p_busy) else $error("busy missing");
    property p_answer; take |-> ##2 result_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("result late");
    property p_rst_bank; $fell(sys_rst_i) |-> !result_o.bank_b; endproperty
    a_rst_bank: assert property (p_rst_bank) else $error("bank b after reset");
    property p_bank;
        take && cmd_i.op == bank_select |-> ##2 result_o.bank_b == $past(cmd_i.bank_b, 2);
    endproperty
    a_bank: assert property (p_bank) else $error("wrong bank");
    property p_bank_flags;
        take && cmd_i.op == bank_select |-> ##2 result_o[2:1] == $past(result_o[2:1], 2);
    endproperty
    a_bank_flags: assert property (p_bank_flags) else $error("flags moved");
    property p_alternate_store_flags;
        take && cmd_i.op == alternate_store |-> ##2 result_o[2:1] == $past(result_o[2:1], 2);
    endproperty
    a_alternate_store_flags: assert property (p_alternate_store_flags) else $error("flags moved");
    property p_rotl; take && cmd_i.op == rotate_left |-> ##2 result_o.carry == result_o.data[0];
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate carry");
    property p_one;
        take && cmd_i.op inside {shift_left_fill_one, shift_right_fill_one} |-> ##2 !result_o.zero;
    endproperty
    a_one: assert property (p_one) else $error("zero set");
endmodule : shift_bank_properties

// file: verif/tb_shift_bank_core.sv
// Self-checking bench for the shift and register bank slice.
`timescale 1ns/100ps
module tb_shift_bank_core;
    import shift_bank_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    command_type cmd_i = '0;
    result_type result_o;
    logic result_valid_o;
    logic busy_o;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] mem [2][16];
    logic [7:0] md;
    logic mc, mz, mb;
    logic [7:0] rnd = 8'h59;
    always #10 clk_sys_i = ~clk_sys_i;
    shift_bank_core dut_u (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i),
        .result_o(result_o),
        .result_valid_o(result_valid_o),
        .busy_o(busy_o)
    );
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic finish_test;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD result expected %h seen %h", exp, seen);
        end
    endtask : check
    task automatic do_reset;
        sys_rst_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        mem = '{default: '0};
        {md, mc, mz, mb} = '0;
    endtask : do_reset
    task automatic issue(input op_type op, input logic [3:0] t, input logic [3:0] s,
                         input logic [7:0] k, input logic f);
        logic [7:0] v;
        logic [8:0] r;
        logic b;
        int i;
        v = mem[mb][t];
        @(negedge clk_sys_i);
        cmd_i = '{op, t, s, k, f, f};
        cmd_valid_i = 1'b1;
        // Holding the request over the execute edge must not start a second one.
        repeat (2) @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
        for (i = 0; i < 4 && result_valid_o !== 1'b1; i++) begin
            @(negedge clk_sys_i);
        end
        // A missing answer counts once; the run still closes through finish_test.
        if (i == 4) begin
            failures++;
            return;
        end
        case (op)
            shift_left_fill_one, shift_right_fill_one: b = 1'b1;
            shift_left_replicate, rotate_right: b = v[0];
            shift_right_replicate, rotate_left: b = v[7];
            shift_left_through_carry, shift_right_through_carry: b = mc;
            default: b = 1'b0;
        endcase
        if (op inside {[shift_left_fill_zero:shift_left_through_carry], rotate_left}) begin
            r = {v, b};
        end else begin
            r = {v[0], b, v[7:1]};
        end
        if (op inside {[shift_left_fill_zero:rotate_right]}) begin
            {mc, md} = r;
            mz = (r[7:0] == 8'h00);
            mem[mb][t] = r[7:0];
        end
        if (op == read_register) md = v;
        if (op == bank_select) mb = f;
        if (op == alternate_store) mem[!mb][t] = f ? k : mem[mb][s];
        check(result_o, {md, mc, mz, mb});
    endtask : issue
    initial begin
        do_reset();
        issue(read_register, 4'h0, 4'h0, 8'h00, 1'b0);
        issue(alternate_store, 4'h3, 4'h0, 8'h80, 1'b1);
        issue(bank_select, 4'h0, 4'h0, 8'h00, 1'b1);
        issue(alternate_store, 4'h3, 4'h3, 8'h00, 1'b0);
        issue(shift_left_fill_zero, 4'h3, 4'h0, 8'h00, 1'b0);
        issue(rotate_right, 4'h3, 4'h0, 8'h00, 1'b0);
        issue(bank_select, 4'h0, 4'h0, 8'h00, 1'b0);
        issue(read_register, 4'h3, 4'h0, 8'h00, 1'b0);
        repeat (600) begin
            rnd = lfsr(rnd);
            issue(op_type'(4'(1 + rnd % 13)), rnd[3:0], rnd[7:4], lfsr(rnd), rnd[5]);
        end
        do_reset();
        issue(read_register, 4'h3, 4'h0, 8'h00, 1'b0);
        finish_test();
    end
endmodule : tb_shift_bank_core
bind shift_bank_core shift_bank_properties chk_u (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .result_o(result_o),
    .result_valid_o(result_valid_o),
    .busy_o(busy_o)
);
